// >>> logic/tpc_core.sv
// Timer counter core with channels, reached over AXI4-Lite.
// Assumes pins asynchronous inputs to aclk; fixed_clk_tick is a pulse.
//
// What this block does
// - Capture mode: reading either value byte holds both until other byte read
// - Writing channel status/control releases the channel's byte latches
// - Capture mode ignores writes to the channel value bytes
// - In debug the read latch state stays frozen; status/control write frees it
// - Value reads in debug return live contents, not the read buffer
// - Compare/PWM byte writes buffer; both bytes move together, immediately if clock off
// - Compare mode with a clock: transfer at next counter change
// - PWM with a clock: transfer as counter steps modulus-1 to modulus
// - Debug writes go straight to the value, leaving partial sequences alone
// - A completed normal sequence overrides values written during debug
// - One 16-bit counter with 16-bit modulus serves every channel
// - Center select forces center PWM and up/down counting; else up
// - Clock source: 00 off, 01 bus, 10 fixed, 11 external; resets 00
// - Clock source freely accessible; off leaves counter and registers intact
// - External clock synchronised to bus clock; must not exceed quarter rate
// - Overflow enable gives a level request while the flag is set
// - Up mode counts to terminal count then wraps, setting overflow
// - Up/down mode turns at terminal count and at zero, one tick each
// - Up/down overflow sets when leaving terminal count downward
// - Counter write clears counter and its read latch
// - Active capture edge copies the counter and sets the channel flag
// - Capture keeps working in debug, taking the frozen count
// - Edge select: 01 rise, 10 fall, 11 both, 00 disconnected
// - Flag clears by read while set then write zero; events restart
`default_nettype none
`include "tpc_regs.svh"

module tpc_core #(
  parameter int N_CH = 4
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [N_CH-1:0] ch_pin,
  input  wire logic            ext_clk_pin,
  input  wire logic            fixed_clk_tick,
  input  wire logic            debug_halt_mode,
  output logic                 irq
);

  localparam logic [5:0] LAST_IDX =
    6'(`TPC_IDX_CH_BASE + `TPC_CH_STRIDE * N_CH);
  logic        aw_held_ff;
  logic [5:0]  aw_idx_ff;
  logic        w_held_ff;
  logic [7:0]  wbyte_ff;
  logic        wlane_ff;
  logic        do_wr;
  logic        wr_en;
  logic        ar_hs;
  logic [5:0]  ar_idx;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic [7:0]  tsc_ff;
  logic        tof_arm_ff;
  logic [15:0] cnt_ff;
  logic        up_ff;
  logic [15:0] mod_ff;
  logic [15:0] mbuf_ff;
  logic        mh_ff;
  logic        ml_ff;
  logic [15:0] cbuf_ff;
  logic        clat_ff;
  logic        clat_hi_ff;
  logic [6:0]  ps_cnt_ff;
  logic [2:0]  ext_sync_ff;
  logic [N_CH-1:0] pin_meta_ff;
  logic [N_CH-1:0] pin_sync_ff;
  logic [15:0] term;
  logic [6:0]  ps_mask;
  logic        src_en;
  logic        tick;
  logic        cnt_wr;
  logic        tsc_wr;
  logic        tsc_rd;
  logic        tof_set;
  tpc_pkg::tpc_clk_src_e  clk_src;
  tpc_pkg::tpc_timebase_s tb;
  tpc_pkg::tpc_chan_acc_s acc [N_CH];
  logic [7:0]  ch_sc_rd [N_CH];
  logic [7:0]  ch_hi_rd [N_CH];
  logic [7:0]  ch_lo_rd [N_CH];
  logic [N_CH-1:0] ch_req;
  // Write channel: address and data taken in either order
  assign do_wr = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_en = do_wr && wlane_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff    <= 1'b0;
      aw_idx_ff     <= 6'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff    <= 1'b1;
      aw_idx_ff     <= s_axi_awaddr[7:2];
      s_axi_awready <= 1'b0;
    end else if (do_wr) begin
      aw_held_ff    <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff    <= 1'b0;
      wbyte_ff     <= `TPC_BYTE_RST;
      wlane_ff     <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff    <= 1'b1;
      wbyte_ff     <= s_axi_wdata[7:0];
      wlane_ff     <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (do_wr) begin
      w_held_ff    <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TPC_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_idx_ff < LAST_IDX) ? `TPC_RESP_OKAY
                                             : `TPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Read channel: side effects happen at the address handshake
  assign ar_hs  = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[7:2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TPC_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  always_comb begin
    rd_byte = `TPC_BYTE_RST;
    rd_hit  = ar_idx < LAST_IDX;
    case (ar_idx)
      `TPC_IDX_TSC:  rd_byte = tsc_ff;
      `TPC_IDX_CNTH: rd_byte = clat_ff ? cbuf_ff[15:8] : cnt_ff[15:8];
      `TPC_IDX_CNTL: rd_byte = clat_ff ? cbuf_ff[7:0] : cnt_ff[7:0];
      `TPC_IDX_MODH: rd_byte = mod_ff[15:8];
      `TPC_IDX_MODL: rd_byte = mod_ff[7:0];
      default:       rd_byte = `TPC_BYTE_RST;
    endcase
    // Strobes are gated by the handshake, the only time data is taken
    for (int i = 0; i < N_CH; i++) begin
      if (acc[i].rd_sc) rd_byte = ch_sc_rd[i];
      if (acc[i].rd_hi) rd_byte = ch_hi_rd[i];
      if (acc[i].rd_lo) rd_byte = ch_lo_rd[i];
    end
  end

  assign tsc_wr = wr_en && (aw_idx_ff == `TPC_IDX_TSC);
  assign tsc_rd = ar_hs && (ar_idx == `TPC_IDX_TSC);
  assign cnt_wr = wr_en && ((aw_idx_ff == `TPC_IDX_CNTH) ||
                            (aw_idx_ff == `TPC_IDX_CNTL));
  // Control register; overflow flag kept in its top bit
  assign clk_src = tpc_pkg::tpc_clk_src_e'(
                   tsc_ff[`TPC_TSC_CLKS_HI:`TPC_TSC_CLKS_LO]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsc_ff     <= `TPC_BYTE_RST;
      tof_arm_ff <= 1'b0;
    end else begin
      if (tsc_wr) begin
        tsc_ff[6:0] <= wbyte_ff[6:0];
      end
      if (tof_set) begin
        tsc_ff[`TPC_TSC_TOF] <= 1'b1;
      end else if (tsc_wr && tof_arm_ff && !wbyte_ff[`TPC_TSC_TOF]) begin
        tsc_ff[`TPC_TSC_TOF] <= 1'b0;
      end
      tof_arm_ff <= !(tof_set || tsc_wr) &&
                    (tof_arm_ff || (tsc_rd && tsc_ff[`TPC_TSC_TOF]));
    end
  end

  // Modulus bytes pair up; a control write cancels a half pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_ff  <= `TPC_WORD_RST;
      mbuf_ff <= `TPC_WORD_RST;
      mh_ff   <= 1'b0;
      ml_ff   <= 1'b0;
    end else if (tsc_wr) begin
      mh_ff <= 1'b0;
      ml_ff <= 1'b0;
    end else if (wr_en && aw_idx_ff == `TPC_IDX_MODH) begin
      mbuf_ff[15:8] <= wbyte_ff;
      mod_ff        <= ml_ff ? {wbyte_ff, mbuf_ff[7:0]} : mod_ff;
      mh_ff         <= !ml_ff;
      ml_ff         <= 1'b0;
    end else if (wr_en && aw_idx_ff == `TPC_IDX_MODL) begin
      mbuf_ff[7:0]  <= wbyte_ff;
      mod_ff        <= mh_ff ? {mbuf_ff[15:8], wbyte_ff} : mod_ff;
      ml_ff         <= !mh_ff;
      mh_ff         <= 1'b0;
    end
  end

  // Sampled inputs; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync_ff <= 3'b000;
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], ext_clk_pin};
      pin_meta_ff <= ch_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  always_comb begin
    case (clk_src)
      tpc_pkg::TPC_CLK_NONE:  src_en = 1'b0;
      tpc_pkg::TPC_CLK_BUS:   src_en = 1'b1;
      tpc_pkg::TPC_CLK_FIXED: src_en = fixed_clk_tick;
      tpc_pkg::TPC_CLK_EXT:   src_en = ext_sync_ff[1] && !ext_sync_ff[2];
      default:                src_en = 1'b0;
    endcase
  end
  // Prescaler divides by two to the power of the field
  assign ps_mask = 7'((8'h01 << tsc_ff[`TPC_TSC_PS_HI:`TPC_TSC_PS_LO])
                      - 8'h01);
  // Counter frozen while halted for debug
  assign tick = src_en && !debug_halt_mode &&
                ((ps_cnt_ff & ps_mask) == ps_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_cnt_ff <= 7'h00;
    end else if (cnt_wr) begin
      ps_cnt_ff <= 7'h00;
    end else if (src_en && !debug_halt_mode) begin
      ps_cnt_ff <= ps_cnt_ff + 7'h01;
    end
  end
  assign term = (mod_ff == `TPC_WORD_RST) ? `TPC_TERM_FREE : mod_ff;
  assign tof_set = tick && (cnt_ff == term) &&
                   (!tsc_ff[`TPC_TSC_CENTER_ALIGNED_SELECT] || up_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= `TPC_WORD_RST;
      up_ff  <= 1'b1;
    end else if (cnt_wr) begin
      cnt_ff <= `TPC_WORD_RST;
      up_ff  <= 1'b1;
    end else if (!tsc_ff[`TPC_TSC_CENTER_ALIGNED_SELECT]) begin
      up_ff <= 1'b1;
      if (tick) begin
        cnt_ff <= (cnt_ff == term) ? `TPC_WORD_RST
                                   : cnt_ff + `TPC_ONE;
      end
    end else if (tick) begin
      if (up_ff && cnt_ff == term) begin
        up_ff  <= 1'b0;
        cnt_ff <= cnt_ff - `TPC_ONE;
      end else if (!up_ff && cnt_ff == `TPC_WORD_RST) begin
        up_ff  <= 1'b1;
        cnt_ff <= `TPC_ONE;
      end else begin
        cnt_ff <= up_ff ? cnt_ff + `TPC_ONE : cnt_ff - `TPC_ONE;
      end
    end
  end

  // Counter read latch, cleared by any counter write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clat_ff    <= 1'b0;
      clat_hi_ff <= 1'b0;
      cbuf_ff    <= `TPC_WORD_RST;
    end else if (cnt_wr) begin
      clat_ff <= 1'b0;
    end else if (ar_hs && (ar_idx == `TPC_IDX_CNTH ||
                           ar_idx == `TPC_IDX_CNTL)) begin
      if (!clat_ff) begin
        clat_ff    <= 1'b1;
        clat_hi_ff <= ar_idx == `TPC_IDX_CNTH;
        cbuf_ff    <= cnt_ff;
      end else if ((ar_idx == `TPC_IDX_CNTH) != clat_hi_ff) begin
        clat_ff <= 1'b0;
      end
    end
  end
  assign tb.tick       = tick;
  assign tb.period_end = tick && (cnt_ff == term - `TPC_ONE) &&
                         (!tsc_ff[`TPC_TSC_CENTER_ALIGNED_SELECT] || up_ff);
  assign tb.clk_off    = clk_src == tpc_pkg::TPC_CLK_NONE;
  assign tb.center_aligned_pwm       = tsc_ff[`TPC_TSC_CENTER_ALIGNED_SELECT];
  assign tb.debug      = debug_halt_mode;
  assign tb.count      = cnt_ff;
  for (genvar n = 0; n < N_CH; n++) begin : g_ch
    localparam logic [5:0] SC_IDX = 6'(`TPC_IDX_CH_BASE + `TPC_CH_STRIDE * n);
    localparam logic [5:0] HI_IDX = SC_IDX + `TPC_CH_OFS_HI;
    localparam logic [5:0] LO_IDX = SC_IDX + `TPC_CH_OFS_LO;
    assign acc[n].wr_sc = wr_en && (aw_idx_ff == SC_IDX);
    assign acc[n].wr_hi = wr_en && (aw_idx_ff == HI_IDX);
    assign acc[n].wr_lo = wr_en && (aw_idx_ff == LO_IDX);
    assign acc[n].rd_sc = ar_hs && (ar_idx == SC_IDX);
    assign acc[n].rd_hi = ar_hs && (ar_idx == HI_IDX);
    assign acc[n].rd_lo = ar_hs && (ar_idx == LO_IDX);
    assign acc[n].wdata = wbyte_ff;
    tpc_channel u_ch (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .acc      (acc[n]),
      .tb       (tb),
      .pin_sync (pin_sync_ff[n]),
      .sc_rdata (ch_sc_rd[n]),
      .hi_rdata (ch_hi_rd[n]),
      .lo_rdata (ch_lo_rd[n]),
      .flag_req (ch_req[n])
    );
  end
  // Level request, held as long as any enabled flag stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (tsc_ff[`TPC_TSC_TOF] && tsc_ff[`TPC_TSC_OVERFLOW_IRQ_ENABLE]) ||
             (|ch_req);
    end
  end

endmodule : tpc_core

`default_nettype wire

// >>> logic/tpc_regs.svh
// Register indices, field positions, reset values for the timer core.
// Assumes byte-wide registers, each in one 32-bit word at 4 x index.
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

`define TPC_IDX_TSC      6'h00
`define TPC_IDX_CNTH     6'h01
`define TPC_IDX_CNTL     6'h02
`define TPC_IDX_MODH     6'h03
`define TPC_IDX_MODL     6'h04
`define TPC_IDX_CH_BASE  6'h05
`define TPC_CH_STRIDE    6'h03
`define TPC_CH_OFS_SC    6'h00
`define TPC_CH_OFS_HI    6'h01
`define TPC_CH_OFS_LO    6'h02

`define TPC_TSC_TOF      7
`define TPC_TSC_OVERFLOW_IRQ_ENABLE     6
`define TPC_TSC_CENTER_ALIGNED_SELECT    5
`define TPC_TSC_CLKS_HI  4
`define TPC_TSC_CLKS_LO  3
`define TPC_TSC_PS_HI    2
`define TPC_TSC_PS_LO    0

`define TPC_CSC_FLAG     7
`define TPC_CSC_IE       6
`define TPC_CSC_MSB      5
`define TPC_CSC_MSA      4
`define TPC_CSC_ELSB     3
`define TPC_CSC_ELSA     2

`define TPC_BYTE_RST     8'h00
`define TPC_WORD_RST     16'h0000
`define TPC_TERM_FREE    16'hffff
`define TPC_ONE          16'h0001
`define TPC_MODE_IC      2'b00
`define TPC_MODE_OC      2'b01
`define TPC_RESP_OKAY    2'b00
`define TPC_RESP_SLVERR  2'b10

`endif

// >>> logic/tpc_pkg.sv
// Types shared by the timer core and its channel slices.
// Assumes tpc_regs.svh for numeric constants other than the clock source codes.
`default_nettype none

package tpc_pkg;

  typedef enum logic [1:0] {
    TPC_CLK_NONE  = 2'b00,
    TPC_CLK_BUS   = 2'b01,
    TPC_CLK_FIXED = 2'b10,
    TPC_CLK_EXT   = 2'b11
  } tpc_clk_src_e;

  // One register access aimed at a channel, all strobes one cycle
  typedef struct packed {
    logic       wr_sc;
    logic       wr_hi;
    logic       wr_lo;
    logic       rd_sc;
    logic       rd_hi;
    logic       rd_lo;
    logic [7:0] wdata;
  } tpc_chan_acc_s;

  // Counter view shared by every channel
  typedef struct packed {
    logic        tick;
    logic        period_end;
    logic        clk_off;
    logic        center_aligned_pwm;
    logic        debug;
    logic [15:0] count;
  } tpc_timebase_s;

endpackage : tpc_pkg

`default_nettype wire

// >>> logic/tpc_channel.sv
// One timer channel: value register, byte coherency, capture, flag.
// Assumes a synchronised pin level and one-cycle access strobes.
`default_nettype none
`include "tpc_regs.svh"

module tpc_channel (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire tpc_pkg::tpc_chan_acc_s acc,
  input  wire tpc_pkg::tpc_timebase_s tb,
  input  wire logic                   pin_sync,
  output logic [7:0]                  sc_rdata,
  output logic [7:0]                  hi_rdata,
  output logic [7:0]                  lo_rdata,
  output logic                        flag_req
);

  logic [6:2]  ctl_ff;
  logic        flag_ff;
  logic        arm_ff;
  logic [15:0] val_ff;
  logic [15:0] rbuf_ff;
  logic [15:0] wbuf_ff;
  logic        rlat_ff;
  logic        rlat_hi_ff;
  logic        wh_ff;
  logic        wl_ff;
  logic        pin_ff;
  logic [15:0] nxt_val;
  logic [15:0] nxt_wbuf;
  logic        nxt_wh;
  logic        nxt_wl;
  logic [1:0]  mode;
  logic [1:0]  els;
  logic        is_ic;
  logic        is_oc;
  logic        is_pwm;
  logic        cap;
  logic        match;
  logic        event_hit;

  assign mode   = ctl_ff[`TPC_CSC_MSB:`TPC_CSC_MSA];
  assign els    = ctl_ff[`TPC_CSC_ELSB:`TPC_CSC_ELSA];
  assign is_ic  = !tb.center_aligned_pwm && (mode == `TPC_MODE_IC);
  assign is_oc  = !tb.center_aligned_pwm && (mode == `TPC_MODE_OC);
  assign is_pwm = tb.center_aligned_pwm || ctl_ff[`TPC_CSC_MSB];
  // Edge select 00 leaves the pin out of the timer
  assign cap    = is_ic && ((els[0] && pin_sync && !pin_ff) ||
                            (els[1] && !pin_sync && pin_ff));
  assign match  = !is_ic && tb.tick && (tb.count == val_ff);
  assign event_hit = cap || match;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= pin_sync;
    end
  end

  always_comb begin
    nxt_val  = val_ff;
    nxt_wbuf = wbuf_ff;
    nxt_wh   = wh_ff;
    nxt_wl   = wl_ff;
    if (acc.wr_sc) begin
      nxt_wh = 1'b0;
      nxt_wl = 1'b0;
    end else if (!is_ic) begin
      if (tb.debug) begin
        // Direct path leaves the pending byte flags alone
        if (acc.wr_hi) begin
          nxt_val[15:8] = acc.wdata;
        end
        if (acc.wr_lo) begin
          nxt_val[7:0] = acc.wdata;
        end
      end else begin
        if (acc.wr_hi) begin
          nxt_wbuf[15:8] = acc.wdata;
          nxt_wh         = 1'b1;
        end
        if (acc.wr_lo) begin
          nxt_wbuf[7:0] = acc.wdata;
          nxt_wl        = 1'b1;
        end
      end
      if (nxt_wh && nxt_wl &&
          (tb.clk_off || (is_oc && tb.tick) ||
           (is_pwm && tb.period_end))) begin
        nxt_val = nxt_wbuf;
        nxt_wh  = 1'b0;
        nxt_wl  = 1'b0;
      end
    end
    if (cap) begin
      nxt_val = tb.count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      val_ff  <= `TPC_WORD_RST;
      wbuf_ff <= `TPC_WORD_RST;
      wh_ff   <= 1'b0;
      wl_ff   <= 1'b0;
    end else begin
      val_ff  <= nxt_val;
      wbuf_ff <= nxt_wbuf;
      wh_ff   <= nxt_wh;
      wl_ff   <= nxt_wl;
    end
  end

  // Read latch stays as it was on entry to debug until a status/control write clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rlat_ff    <= 1'b0;
      rlat_hi_ff <= 1'b0;
      rbuf_ff    <= `TPC_WORD_RST;
    end else if (acc.wr_sc) begin
      rlat_ff <= 1'b0;
    end else if (!tb.debug && is_ic && (acc.rd_hi || acc.rd_lo)) begin
      if (!rlat_ff) begin
        rlat_ff    <= 1'b1;
        rlat_hi_ff <= acc.rd_hi;
        rbuf_ff    <= val_ff;
      end else if (acc.rd_hi != rlat_hi_ff) begin
        rlat_ff <= 1'b0;
      end
    end
  end

  assign hi_rdata = (rlat_ff && !tb.debug) ? rbuf_ff[15:8]
                                           : val_ff[15:8];
  assign lo_rdata = (rlat_ff && !tb.debug) ? rbuf_ff[7:0]
                                           : val_ff[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_ff <= 5'h00;
    end else if (acc.wr_sc) begin
      ctl_ff <= acc.wdata[6:2];
    end
  end

  // A new event restarts the clear sequence, so set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= 1'b0;
      arm_ff  <= 1'b0;
    end else if (event_hit) begin
      flag_ff <= 1'b1;
      arm_ff  <= 1'b0;
    end else if (acc.rd_sc && flag_ff) begin
      arm_ff <= 1'b1;
    end else if (acc.wr_sc) begin
      arm_ff <= 1'b0;
      if (arm_ff && !acc.wdata[`TPC_CSC_FLAG]) begin
        flag_ff <= 1'b0;
      end
    end
  end

  assign sc_rdata = {flag_ff, ctl_ff, 2'b00};
  assign flag_req = flag_ff && ctl_ff[`TPC_CSC_IE];

endmodule : tpc_channel

`default_nettype wire

// >>> verification/tpc_core_chk.sv
// Port checker for tpc_core: bus answers, read data, request line.
// Assumes the core's ports and its synchronous active-low reset.
`default_nettype none
`include "tpc_regs.svh"
module tpc_core_chk #(parameter int N_CH = 4) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       ar_hs;
  logic       ar_bad;
  logic [2:0] wr_age_ff;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign ar_bad = s_axi_araddr[7:2] >= 6'(5 + 3 * N_CH);
  // Cycles since a write was taken, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn || (s_axi_awvalid && s_axi_awready)) wr_age_ff <= 3'h0;
    else if (wr_age_ff != 3'h7) wr_age_ff <= wr_age_ff + 3'h1;
  end
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_r_ans;
    ar_hs |=> s_axi_rvalid;
  endproperty
  property p_r_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_r_err;
    ar_hs && ar_bad |=> s_axi_rresp == `TPC_RESP_SLVERR && s_axi_rdata == 0;
  endproperty
  property p_r_ok;
    ar_hs && !ar_bad |=> s_axi_rresp == `TPC_RESP_OKAY;
  endproperty
  property p_irq_rst;
    $rose(aresetn) |-> !irq;
  endproperty
  // Flags only clear by a write, so the request only drops after one
  property p_irq_keep;
    $fell(irq) |-> wr_age_ff < 3'h6;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  a_b_ans: assert property (p_b_ans) else $error("no write answer");
  a_r_ans: assert property (p_r_ans) else $error("no read answer");
  a_r_byte: assert property (p_r_byte) else $error("upper bits set");
  a_r_err: assert property (p_r_err) else $error("bad unmapped read");
  a_r_ok: assert property (p_r_ok) else $error("bad mapped read");
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
  a_irq_keep: assert property (p_irq_keep) else $error("irq lost");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (ar_hs && ar_bad);
  c_irq: cover property ($rose(irq));
endmodule : tpc_core_chk
bind tpc_core tpc_core_chk #(.N_CH(N_CH)) tpc_core_chk_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq
);
`default_nettype wire

// >>> verification/tpc_pin_model.sv
// Far-side pins: channel pin levels and an external clock source.
// Assumes aclk is the core's bus clock.
`default_nettype none
module tpc_pin_model #(parameter int N_CH = 4) (
  input  wire logic            aclk,
  input  wire logic            ext_run,
  input  wire logic [N_CH-1:0] lvl,
  output logic [N_CH-1:0]      ch_pin,
  output logic                 ext_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph;
  // Quarter bus rate, the fastest the source may go; still when idle
  always @(posedge aclk) begin
    if (!ext_run) {ph, ext_clk_pin} <= 2'b00;
    else {ph, ext_clk_pin} <= {~ph, ext_clk_pin ^ ph};
  end
  assign ch_pin = lvl;
endmodule : tpc_pin_model
`default_nettype wire

// >>> verification/test_timer_counter_capture_core.sv
// Bench for tpc_core: register tasks over AXI4-Lite, directed tests.
// Assumes byte registers at 4 x index, channel n at index 5+3n.
`default_nettype none
module test_timer_counter_capture_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, ext_clk;
  logic        ext_run, fix_tick, dbg;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  lvl, ch_pin;
  int          fail_count, total_checks, cyc;
  tpc_core #(.N_CH(4)) tpc_core_inst (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ch_pin,
    .ext_clk_pin(ext_clk), .fixed_clk_tick(fix_tick),
    .debug_halt_mode(dbg), .irq);
  tpc_pin_model #(.N_CH(4)) tpc_pin_model_inst (.aclk, .ext_run, .lvl,
    .ch_pin, .ext_clk_pin(ext_clk));
  task automatic final_report();
    $display("checks=%0d fails=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata[7:0], exp);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk) fix_tick <= 1'b1;
      @(posedge aclk) fix_tick <= 1'b0;
    end
  endtask : ticks
  task automatic edge1(input logic v);
    lvl[1] <= v;
    repeat (6) @(posedge aclk);
  endtask : edge1
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, fix_tick, dbg, ext_run} = '0;
    {awaddr, araddr, wdata, lvl, aresetn, cyc} = '0;
    {fail_count, total_checks} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(6'h00, 8'h00);
    rd(6'h11, 8'h00);
    $display("reset test done");
    wr(6'h05, 8'h10);
    wr(6'h06, 8'h12);
    wr(6'h07, 8'h34);
    rd(6'h06, 8'h12);
    wr(6'h06, 8'h56);
    dbg <= 1'b1;
    wr(6'h07, 8'h99);
    rd(6'h07, 8'h99);
    dbg <= 1'b0;
    wr(6'h07, 8'h78);
    rd(6'h06, 8'h56);
    rd(6'h07, 8'h78);
    $display("compare and debug test done");
    wr(6'h00, 8'h08);
    wr(6'h06, 8'hab);
    wr(6'h07, 8'hcd);
    rd(6'h07, 8'hcd);
    wr(6'h06, 8'h11);
    wr(6'h05, 8'h10);
    wr(6'h07, 8'h22);
    rd(6'h06, 8'hab);
    $display("buffer test done");
    wr(6'h03, 8'h00);
    wr(6'h04, 8'h03);
    wr(6'h02, 8'h00);
    wr(6'h00, 8'h48);
    repeat (20) @(posedge aclk);
    chk({7'h0, irq}, 8'h01);
    wr(6'h00, 8'h40);
    rd(6'h00, 8'hc0);
    wr(6'h00, 8'h40);
    rd(6'h00, 8'h40);
    chk({7'h0, irq}, 8'h00);
    $display("overflow test done");
    wr(6'h04, 8'h00);
    wr(6'h03, 8'h00);
    wr(6'h00, 8'h10);
    wr(6'h02, 8'h00);
    ticks(5);
    wr(6'h08, 8'h04);
    edge1(1'b1);
    rd(6'h0a, 8'h05);
    rd(6'h09, 8'h00);
    rd(6'h08, 8'h84);
    wr(6'h0a, 8'hff);
    rd(6'h09, 8'h00);
    ticks(2);
    edge1(1'b0);
    edge1(1'b1);
    rd(6'h0a, 8'h05);
    rd(6'h0a, 8'h07);
    wr(6'h00, 8'h18);
    wr(6'h02, 8'h00);
    ext_run <= 1'b1;
    repeat (40) @(posedge aclk);
    ext_run <= 1'b0;
    rd(6'h02, 8'h0a);
    rd(6'h01, 8'h00);
    $display("capture test done");
    final_report();
  end
endmodule : test_timer_counter_capture_core
`default_nettype wire
